// [src/slow_osc_control.sv]
// Slow crystal oscillator control, system write lock and clock-fail interrupt source
module slow_osc_control
   import slow_osc_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // System status
   input wire logic slow_osc_is_system_clock_source_in,
   input wire logic sleep_in,
   input wire logic clock_fail_event_in,
   // Oscillator and interrupt controller
   output logic slow_osc_run_out,
   output logic clock_fail_irq_out,
   output logic [2:0] clock_fail_priority_out,
   output logic [1:0] clock_fail_subpriority_out,
   output logic [7:0] clock_fail_vector_out,
   output logic [31:0] clock_fail_vector_addr_out,
   output logic system_unlocked_out
);

   state_t s_q;
   state_t s_d;
   reg_req_t req;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Spacing scales the vector stride in units of 32 bytes
   function automatic logic [31:0] vec_addr(input logic [4:0] spacing);
      logic [31:0] stride;
      stride = {27'h0000000, spacing} << 5;
      vec_addr = EXCEPTION_BASE_RESET + VECTOR_TABLE_OFFSET
                 + 32'(CLOCK_FAIL_VECTOR) * stride; // [RQ21]
   endfunction

   function automatic logic is_wr(input reg_req_t r, input logic [3:0] a);
      is_wr = r.wr && (r.addr == a);
   endfunction

   assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rdata = WORD_ZERO;

      // Any write elsewhere between keys breaks the sequence
      case (s_q.lock)
         LOCK_CLOSED: begin
            if (is_wr(req, ADDR_UNLOCK_KEY) && req.wdata == UNLOCK_KEY_FIRST) begin
               s_d.lock = LOCK_HALF; // [RQ22]
            end
         end
         LOCK_HALF: begin
            if (is_wr(req, ADDR_UNLOCK_KEY) && req.wdata == UNLOCK_KEY_SECOND) begin
               s_d.lock = LOCK_OPEN; // [RQ22]
            end else if (req.wr || req.rd) begin
               s_d.lock = LOCK_CLOSED; // [RQ22]
            end
         end
         LOCK_OPEN: begin
            if (is_wr(req, ADDR_UNLOCK_KEY)) begin
               s_d.lock = LOCK_CLOSED; // [RQ22]
            end
         end
         default: begin
            s_d.lock = LOCK_CLOSED;
         end
      endcase

      // Single lock state gates every protected register
      if (is_wr(req, ADDR_OSC_CONTROL) && s_q.lock == LOCK_OPEN) begin // [RQ5] [RQ6]
         s_d.slow_osc_enable_bit = req.wdata[SLOW_OSC_ENABLE_POS]; // [RQ1]
      end

      if (is_wr(req, ADDR_INT_ENABLE_ONE)) begin
         s_d.clock_fail_int_enable = req.wdata[CLOCK_FAIL_POS];
      end
      if (is_wr(req, ADDR_INT_PRIORITY_EIGHT)) begin
         s_d.clock_fail_priority = req.wdata[PRIO_MSB:PRIO_LSB];
         s_d.clock_fail_subpriority = req.wdata[SUBPRIO_MSB:SUBPRIO_LSB];
      end
      if (is_wr(req, ADDR_VECTOR_SPACING)) begin
         s_d.vector_spacing = req.wdata[4:0];
      end

      // Flag: direct write or write-one-to-clear; event wins over clear
      if (is_wr(req, ADDR_INT_FLAG_ONE)) begin
         s_d.clock_fail_flag = req.wdata[CLOCK_FAIL_POS];
      end
      if (is_wr(req, ADDR_FLAG_CLEAR) && req.wdata[CLOCK_FAIL_POS]) begin
         s_d.clock_fail_flag = 1'b0;
      end
      if (clock_fail_event_in) begin
         s_d.clock_fail_flag = 1'b1; // [RQ12] [RQ23] [RQ11]
      end

      // Enable bit or use as system clock keeps it running, sleep included
      s_d.osc_run = s_q.slow_osc_enable_bit || slow_osc_is_system_clock_source_in; // [RQ2] [RQ3] [RQ4] [RQ10]

      // Priority zero never requests; ranking is done by the controller
      s_d.irq_req = s_q.clock_fail_flag && s_q.clock_fail_int_enable
                    && (s_q.clock_fail_priority != PRIO_NONE); // [RQ13] [RQ15] [RQ16] [RQ17] [RQ19]

      // Registered copies keep every output glitch free at the controller
      s_d.unlocked = (s_d.lock == LOCK_OPEN); // [RQ6] [RQ22]
      s_d.vector_num = CLOCK_FAIL_VECTOR; // [RQ20]
      s_d.vector_addr = vec_addr(s_d.vector_spacing); // [RQ21]

      if (req.rd) begin
         case (req.addr)
            ADDR_OSC_CONTROL: begin
               s_d.rdata[SLOW_OSC_ENABLE_POS] = s_q.slow_osc_enable_bit;
            end
            ADDR_INT_FLAG_ONE: begin
               s_d.rdata[CLOCK_FAIL_POS] = s_q.clock_fail_flag;
            end
            ADDR_INT_ENABLE_ONE: begin
               s_d.rdata[CLOCK_FAIL_POS] = s_q.clock_fail_int_enable;
            end
            ADDR_INT_PRIORITY_EIGHT: begin
               s_d.rdata[PRIO_MSB:PRIO_LSB] = s_q.clock_fail_priority;
               s_d.rdata[SUBPRIO_MSB:SUBPRIO_LSB] = s_q.clock_fail_subpriority;
            end
            ADDR_STATUS: begin
               s_d.rdata[STAT_RUN_POS] = s_q.osc_run;
               s_d.rdata[STAT_LOCK_POS] = (s_q.lock == LOCK_OPEN);
               s_d.rdata[STAT_REQ_POS] = s_q.irq_req;
            end
            ADDR_VECTOR_ADDR: begin
               s_d.rdata = vec_addr(s_q.vector_spacing);
            end
            ADDR_VECTOR_SPACING: begin
               s_d.rdata[4:0] = s_q.vector_spacing;
            end
            default: begin
               s_d.rdata = WORD_ZERO;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         // Vector address reset value matches the reset spacing
         s_q <= '{
            lock: LOCK_CLOSED,
            slow_osc_enable_bit: 1'b0,
            clock_fail_flag: 1'b0,
            clock_fail_int_enable: 1'b0,
            clock_fail_priority: PRIO_NONE,
            clock_fail_subpriority: 2'h0,
            vector_spacing: VECTOR_SPACING_RESET,
            osc_run: 1'b0,
            irq_req: 1'b0,
            rdata: WORD_ZERO,
            unlocked: 1'b0,
            vector_num: CLOCK_FAIL_VECTOR,
            vector_addr: VECTOR_ADDR_RESET
         };
      end else begin
         s_q <= s_d;
      end
   end

   // Sleep needs no gating: an enabled oscillator runs on regardless
   logic unused_sleep;
   assign unused_sleep = sleep_in;

   assign rdata_out = s_q.rdata;
   assign slow_osc_run_out = s_q.osc_run;
   assign clock_fail_irq_out = s_q.irq_req;
   assign clock_fail_priority_out = s_q.clock_fail_priority;
   assign clock_fail_subpriority_out = s_q.clock_fail_subpriority;
   assign clock_fail_vector_out = s_q.vector_num; // [RQ20] [RQ18]
   assign clock_fail_vector_addr_out = s_q.vector_addr;
   assign system_unlocked_out = s_q.unlocked;

endmodule

// [src/slow_osc_pkg.sv]
// Constants and types for the slow oscillator control and clock-fail interrupt block
// Operation
// (RQ1) Writing enable bit one starts slow oscillator
// (RQ2) Oscillator off when disabled and not system clock
// (RQ3) Clearing enable cannot stop active system clock
// (RQ4) Enabled oscillator keeps running during sleep
// (RQ5) Control register ignores writes while locked
// (RQ6) One lock guards all protected registers
// (RQ7) Software sets enable before switching clock away
// (RQ8) Software waits about 32 ms before calendar
// (RQ9) Software waits about 10 ms before timer
// (RQ10) Oscillator supplies calendar and timer time base
// (RQ11) Clock-fail event is the only interrupt source
// (RQ12) Failure sets clock-fail flag bit 14
// (RQ13) Enabled flag requests processor interrupt
// (RQ14) Service routine clears flag before finishing
// (RQ15) Priority bits 20:18, zero suppresses request
// (RQ16) Higher priority group pre-empts serviced interrupt
// (RQ17) Subpriority ranks within group, three highest
// (RQ18) Equal ties resolved by lower vector number
// (RQ19) Losers raised again after current flag clears
// (RQ20) Vector number 33, request number 45
// (RQ21) Vector address 80000620 or 80004400 by spacing
// (RQ22) Two back-to-back keys unlock, other value locks
// (RQ23) Flag stays set until software clears it
package slow_osc_pkg;

   // ---------------------------------------------------------------
   // Register map (word index; byte address is index times four)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_OSC_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_UNLOCK_KEY = 4'h1;
   localparam logic [3:0] ADDR_INT_FLAG_ONE = 4'h2;
   localparam logic [3:0] ADDR_INT_ENABLE_ONE = 4'h3;
   localparam logic [3:0] ADDR_INT_PRIORITY_EIGHT = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h5;
   localparam logic [3:0] ADDR_VECTOR_ADDR = 4'h6;
   localparam logic [3:0] ADDR_VECTOR_SPACING = 4'h7;
   localparam logic [3:0] ADDR_FLAG_CLEAR = 4'h8;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int SLOW_OSC_ENABLE_POS = 1;
   localparam int CLOCK_FAIL_POS = 14;
   localparam int PRIO_LSB = 18;
   localparam int PRIO_MSB = 20;
   localparam int SUBPRIO_LSB = 16;
   localparam int SUBPRIO_MSB = 17;
   localparam int STAT_RUN_POS = 0;
   localparam int STAT_LOCK_POS = 1;
   localparam int STAT_REQ_POS = 2;

   // ---------------------------------------------------------------
   // Keys, identifiers, vector table
   // ---------------------------------------------------------------
   localparam logic [31:0] UNLOCK_KEY_FIRST = 32'hAA996655;
   localparam logic [31:0] UNLOCK_KEY_SECOND = 32'h556699AA;
   localparam logic [7:0] CLOCK_FAIL_VECTOR = 8'h21;
   localparam logic [7:0] CLOCK_FAIL_IRQ = 8'h2D;
   localparam logic [31:0] EXCEPTION_BASE_RESET = 32'h80000000;
   localparam logic [31:0] VECTOR_TABLE_OFFSET = 32'h00000200;
   localparam logic [4:0] VECTOR_SPACING_RESET = 5'h01;
   localparam logic [31:0] VECTOR_ADDR_RESET = 32'h80000620;
   localparam logic [2:0] PRIO_NONE = 3'h0;
   localparam logic [31:0] WORD_ZERO = 32'h00000000;

   // ---------------------------------------------------------------
   // Software guidance times, not enforced in hardware
   // ---------------------------------------------------------------
   localparam int CALENDAR_SETTLE_MS = 32;
   localparam int TIMER_SETTLE_MS = 10;
   localparam int CLK_MHZ = 200;
   localparam longint CALENDAR_SETTLE_CYC = longint'(CALENDAR_SETTLE_MS) * 1000 * CLK_MHZ;
   localparam longint TIMER_SETTLE_CYC = longint'(TIMER_SETTLE_MS) * 1000 * CLK_MHZ;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      LOCK_CLOSED = 3'b001,
      LOCK_HALF = 3'b010,
      LOCK_OPEN = 3'b100
   } lock_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      lock_state_t lock;
      logic slow_osc_enable_bit;
      logic clock_fail_flag;
      logic clock_fail_int_enable;
      logic [2:0] clock_fail_priority;
      logic [1:0] clock_fail_subpriority;
      logic [4:0] vector_spacing;
      logic osc_run;
      logic irq_req;
      logic [31:0] rdata;
      logic unlocked;
      logic [7:0] vector_num;
      logic [31:0] vector_addr;
   } state_t;

endpackage

// [testbench/slow_osc_control_asserts.sv]
// Port checker for the slow oscillator control block
module slow_osc_control_asserts (
   // Watched ports
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic slow_osc_is_system_clock_source_in,
   input wire logic sleep_in,
   input wire logic slow_osc_run_out,
   input wire logic clock_fail_irq_out,
   input wire logic [2:0] clock_fail_priority_out,
   input wire logic [7:0] clock_fail_vector_out,
   input wire logic [31:0] clock_fail_vector_addr_out,
   input wire logic system_unlocked_out
);
   default clocking dc @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   // --------
   // Two cycles of history cover the one-cycle lag of run
   // --------
   AST_SYSTEM_CLOCK_SOURCE_RUN: assert property (slow_osc_is_system_clock_source_in |=> slow_osc_run_out)
      else $error("slow osc stopped while system clock");
   AST_SLEEP_RUN: assert property (sleep_in && slow_osc_run_out && !$past(wr_in)
      && !$past(slow_osc_is_system_clock_source_in) && !$past(slow_osc_is_system_clock_source_in, 2) |=> slow_osc_run_out)
      else $error("enabled slow osc stopped in sleep");
   AST_OFF_STAYS: assert property (!slow_osc_run_out && !$past(wr_in) && !slow_osc_is_system_clock_source_in
      && !$past(slow_osc_is_system_clock_source_in) |=> !slow_osc_run_out)
      else $error("slow osc started without cause");
   AST_VECTOR_NUM: assert property (clock_fail_vector_out == 8'h21)
      else $error("wrong vector number");
   AST_VADDR_RESET: assert property ($fell(rst_in) |-> clock_fail_vector_addr_out == 32'h80000620)
      else $error("wrong vector address after reset");
   AST_UNLOCK_KEYS: assert property ($rose(system_unlocked_out) |-> $past(wr_in)
      && $past(addr_in) == 4'h1 && $past(wdata_in) == 32'h556699AA)
      else $error("unlock without second key");
   AST_PRIO_ZERO: assert property (clock_fail_priority_out == 3'h0
      && $past(clock_fail_priority_out) == 3'h0 |-> !clock_fail_irq_out)
      else $error("request at priority zero");
   AST_IRQ_HOLD: assert property (clock_fail_irq_out && !wr_in && !$past(wr_in) |=> clock_fail_irq_out)
      else $error("request dropped without a write");
endmodule

bind slow_osc_control slow_osc_control_asserts chk (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in,
   .slow_osc_is_system_clock_source_in, .sleep_in, .slow_osc_run_out, .clock_fail_irq_out, .clock_fail_priority_out,
   .clock_fail_vector_out, .clock_fail_vector_addr_out, .system_unlocked_out);

// [testbench/irq_ctrl_model.sv]
// Interrupt controller model that takes the clock-fail request
module irq_ctrl_model
   import slow_osc_pkg::*;
(
   // Request side
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic irq_in,
   input wire logic [2:0] prio_in,
   input wire logic [7:0] vector_in,
   // Service record
   output int taken_out,
   output logic [7:0] vector_out
);
   logic irq_q;
   // Level request: only a new rise counts as a new service
   always_ff @(posedge clk_in) begin
      irq_q <= irq_in & !rst_in;
      if (rst_in) begin
         taken_out <= 0;
         vector_out <= 8'h00;
      end else if (irq_in && !irq_q && prio_in != PRIO_NONE) begin
         taken_out <= taken_out + 1;
         vector_out <= vector_in;
      end
   end
endmodule

// [testbench/test_slow_osc_control.sv]
// Self-checking bench for the slow oscillator control block
module test_slow_osc_control
   import slow_osc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, sleep_in = 1'b0;
   logic slow_osc_is_system_clock_source_in = 1'b0, clock_fail_event_in = 1'b0;
   logic [3:0] addr_in = 4'h0;
   logic [31:0] wdata_in = 32'h0, rdata_out, clock_fail_vector_addr_out;
   logic slow_osc_run_out, clock_fail_irq_out, system_unlocked_out;
   logic [2:0] clock_fail_priority_out, prio_m = 3'h0;
   logic [1:0] clock_fail_subpriority_out, sub_m = 2'h0;
   logic [7:0] clock_fail_vector_out, vec_seen;
   logic en_m = 1'b0, flag_m = 1'b0, ien_m = 1'b0, open_m = 1'b0, half_m = 1'b0;
   logic [4:0] sp_m = 5'h01;
   int errors, comparisons, cycles, taken;
   int sp_q[$] = '{1, 2, 4, 8, 16};
   logic [31:0] vtab_q[$] = '{32'h80000620, 32'h80000A40, 32'h80001280, 32'h80002300, 32'h80004400};
   logic [3:0] rdl_q[$] = '{0, 2, 3, 4, 5, 6, 7, 9};

   slow_osc_control uut (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .slow_osc_is_system_clock_source_in, .sleep_in, .clock_fail_event_in, .slow_osc_run_out, .clock_fail_irq_out,
      .clock_fail_priority_out, .clock_fail_subpriority_out, .clock_fail_vector_out,
      .clock_fail_vector_addr_out, .system_unlocked_out);
   irq_ctrl_model ctrl (.clk_in, .rst_in, .irq_in(clock_fail_irq_out), .prio_in(clock_fail_priority_out),
      .vector_in(clock_fail_vector_out), .taken_out(taken), .vector_out(vec_seen));

   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_sim;
      end
   end
   // --------
   // Bus tasks and the register model
   // --------
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      // First key only counts from the fully closed state
      {open_m, half_m} = (a != ADDR_UNLOCK_KEY) ? {open_m, 1'b0} :
         {half_m && d == UNLOCK_KEY_SECOND, !open_m && !half_m && d == UNLOCK_KEY_FIRST};
      case (a)
         ADDR_OSC_CONTROL: if (open_m) en_m = d[1];
         ADDR_INT_FLAG_ONE: flag_m = d[14];
         ADDR_INT_ENABLE_ONE: ien_m = d[14];
         ADDR_INT_PRIORITY_EIGHT: {prio_m, sub_m} = d[20:16];
         ADDR_VECTOR_SPACING: sp_m = d[4:0];
         ADDR_FLAG_CLEAR: if (d[14]) flag_m = 1'b0;
         default: ;
      endcase
   endtask
   function automatic logic [31:0] exp_rd(input logic [3:0] a);
      case (a)
         ADDR_OSC_CONTROL: return {30'h0, en_m, 1'b0};
         ADDR_INT_FLAG_ONE: return {17'h0, flag_m, 14'h0};
         ADDR_INT_ENABLE_ONE: return {17'h0, ien_m, 14'h0};
         ADDR_INT_PRIORITY_EIGHT: return {11'h0, prio_m, sub_m, 16'h0};
         ADDR_STATUS: return {29'h0, flag_m & ien_m & (prio_m != 3'h0), open_m, en_m | slow_osc_is_system_clock_source_in};
         ADDR_VECTOR_ADDR: return 32'h80000200 + 32'(sp_m) * 32'h420;
         ADDR_VECTOR_SPACING: return {27'h0, sp_m};
         default: return 32'h0;
      endcase
   endfunction
   task rdm(input logic [3:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      half_m = 1'b0;
      #1 chk("rdata", exp_rd(a), rdata_out);
   endtask
   // Run and request lag the cause by two edges at most
   task ports;
      repeat (2) @(posedge clk_in);
      #1 chk("run", en_m | slow_osc_is_system_clock_source_in, slow_osc_run_out);
      chk("irq", flag_m & ien_m & (prio_m != 3'h0), clock_fail_irq_out);
      chk("unlocked", open_m, system_unlocked_out);
   endtask
   task fail;
      @(posedge clk_in);
      clock_fail_event_in <= 1'b1;
      @(posedge clk_in);
      clock_fail_event_in <= 1'b0;
      flag_m = 1'b1;
   endtask
   task end_sim;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // --------
   // Main sequence
   // --------
   initial begin
      void'($urandom(32'h478685CA));
      repeat (12) @(posedge clk_in);
      rst_in <= 1'b0;
      foreach (rdl_q[i]) rdm(rdl_q[i]);
      $display("reset values done");
      wr(ADDR_OSC_CONTROL, 32'h2);
      ports;
      wr(ADDR_UNLOCK_KEY, UNLOCK_KEY_FIRST);
      wr(ADDR_UNLOCK_KEY, UNLOCK_KEY_SECOND);
      wr(ADDR_OSC_CONTROL, 32'h2);
      sleep_in <= 1'b1;
      // Crystal settle waits dwarf this run, so none are modelled
      ports;
      rdm(ADDR_STATUS);
      wr(ADDR_OSC_CONTROL, 32'h0);
      slow_osc_is_system_clock_source_in <= 1'b1;
      ports;
      @(posedge clk_in);
      slow_osc_is_system_clock_source_in <= 1'b0;
      ports;
      wr(ADDR_UNLOCK_KEY, 32'h33333333);
      wr(ADDR_OSC_CONTROL, 32'h2);
      ports;
      wr(ADDR_UNLOCK_KEY, UNLOCK_KEY_FIRST);
      wr(ADDR_VECTOR_ADDR, 32'h0);
      wr(ADDR_UNLOCK_KEY, UNLOCK_KEY_SECOND);
      ports;
      $display("oscillator and lock done");
      foreach (sp_q[i]) begin
         wr(ADDR_VECTOR_SPACING, 32'(sp_q[i]));
         rdm(ADDR_VECTOR_ADDR);
         chk("vaddr", vtab_q[i], clock_fail_vector_addr_out);
      end
      $display("vector table done");
      wr(ADDR_INT_PRIORITY_EIGHT, {11'h0, 3'($urandom_range(7, 1)), 2'($urandom), 16'h0});
      fail;
      ports;
      chk("prio", prio_m, clock_fail_priority_out);
      chk("subprio", sub_m, clock_fail_subpriority_out);
      rdm(ADDR_INT_FLAG_ONE);
      wr(ADDR_INT_ENABLE_ONE, 32'h4000);
      ports;
      fail;
      ports;
      chk("taken", 32'h1, taken);
      chk("vector", 32'h21, vec_seen);
      wr(ADDR_FLAG_CLEAR, 32'h4000);
      ports;
      wr(ADDR_INT_PRIORITY_EIGHT, 32'h0);
      fail;
      ports;
      wr(ADDR_INT_FLAG_ONE, 32'h0);
      rdm(ADDR_INT_FLAG_ONE);
      // Clear and failure in one cycle: the failure must win
      @(posedge clk_in);
      addr_in <= ADDR_FLAG_CLEAR;
      wdata_in <= 32'h00004000;
      wr_in <= 1'b1;
      clock_fail_event_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      clock_fail_event_in <= 1'b0;
      flag_m = 1'b1;
      rdm(ADDR_INT_FLAG_ONE);
      $display("interrupt done");
      end_sim;
   end
endmodule
